//--- inc/tsr_regs.svh
// Register map, reset values and timing constants of the thermal/test register block
`ifndef TSR_REGS_SVH
`define TSR_REGS_SVH

// Register addresses (7-bit register space)
`define TSR_ADDR_TEMP_CTRL   7'h4e
`define TSR_ADDR_TEMP_RESULT 7'h4f
`define TSR_ADDR_RX_SENS     7'h58
`define TSR_ADDR_PA_A        7'h5a
`define TSR_ADDR_PA_B        7'h5c
`define TSR_ADDR_FADING      7'h6f
`define TSR_ADDR_OFFSET      7'h71

// Field positions in the temperature control register
`define TSR_TEMP_START_BIT   3
`define TSR_TEMP_RUN_BIT     2
`define TSR_TEMP_CTRL_FIXED  8'h01

// Reset values
`define TSR_RST_RX_SENS      8'h1b
`define TSR_RST_PA_A         8'h55
`define TSR_RST_PA_B         8'h70
`define TSR_RST_FADING       8'h30
`define TSR_RST_OFFSET       8'h00
`define TSR_RST_TEMP         8'h00
`define TSR_RD_UNMAPPED      8'h00

// Frequency offset step per offset LSB, in Hz
`define TSR_HZ_PER_LSB       17'h001e8

// Timing: clock rate and times in their own units
`define TSR_CLK_HZ           10000000
`define TSR_READY_WAIT_US    5000
`define TSR_MEAS_TIME_US     100
`define TSR_US_PER_S         1000000

`endif

//--- inc/tsr_pkg.sv
// Types shared by the thermal/test register block
`default_nettype none

package tsr_pkg;

	typedef enum logic [1:0] {
		TSR_BOOT,
		TSR_IDLE,
		TSR_MEAS
	} tsr_phase_t;

	typedef struct packed {
		logic       s1;
		logic       s2;
		logic       s3;
		logic       q;
	} tsr_sync_state_t;

	typedef struct packed {
		logic       sck_prev;
		logic [2:0] bitcnt;
		logic       is_cmd;
		logic       wnr;
		logic [6:0] addr;
		logic [7:0] shin;
		logic [7:0] shout;
		logic       miso;
		logic       miso_oe;
		logic       wr_stb;
		logic [6:0] wr_addr;
		logic [7:0] wr_data;
	} tsr_spi_state_t;

	typedef struct packed {
		tsr_phase_t  phase;
		logic [15:0] ready_cnt;
		logic [15:0] meas_cnt;
		logic        reference_clock_output;
		logic        ready;
		logic [7:0]  temp_result;
		logic [7:0]  rx_sens;
		logic [7:0]  pa_a;
		logic [7:0]  pa_b;
		logic [7:0]  fading;
		logic [7:0]  offset;
		logic [16:0] offset_hz;
		logic        busy;
	} tsr_top_state_t;

endpackage

`default_nettype wire

//--- src/tsr_sync3.sv
// Three-stage input synchroniser that accepts a change once stages two and three agree
`timescale 1ns/100ps
`default_nettype none

module tsr_sync3
	import tsr_pkg::*;
#(
	parameter logic RESET_LEVEL = 1'b0
) (
	input  wire logic ref_clk_in,
	input  wire logic resetn_in,
	input  wire logic async_in,
	output logic      sync_out
);

	tsr_sync_state_t s_ff;
	tsr_sync_state_t nxt_s;

	////////////////////////////////////////////////////////////////////////////////
	// Stage one feeds only stage two; the filter looks at stages two and three
	always_comb begin
		nxt_s    = s_ff;
		nxt_s.s1 = async_in;
		nxt_s.s2 = s_ff.s1;
		nxt_s.s3 = s_ff.s2;
		if (s_ff.s2 == s_ff.s3) begin
			nxt_s.q = s_ff.s3;
		end
	end

	always_ff @(posedge ref_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			s_ff <= {4{RESET_LEVEL}};
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign sync_out = s_ff.q;

endmodule // tsr_sync3

`default_nettype wire

//--- src/tsr_spi_slave.sv
// SPI register-port slave: mode 0, MSB first, address byte then data bytes with auto-increment
`timescale 1ns/100ps
`default_nettype none

module tsr_spi_slave
	import tsr_pkg::*;
(
	input  wire logic       ref_clk_in,
	input  wire logic       resetn_in,
	input  wire logic       enable_in,
	input  wire logic       sck_in,
	input  wire logic       nss_n_in,
	input  wire logic       mosi_in,
	input  wire logic [7:0] rd_data_in,
	output logic      [6:0] rd_addr_out,
	output logic            wr_stb_out,
	output logic      [6:0] wr_addr_out,
	output logic      [7:0] wr_data_out,
	output logic            miso_out,
	output logic            miso_oe_out
);

	tsr_spi_state_t s_ff;
	tsr_spi_state_t nxt_s;
	logic           sck_rise;
	logic           sck_fall;
	logic [7:0]     shifted;

	assign sck_rise = sck_in & ~s_ff.sck_prev;
	assign sck_fall = ~sck_in & s_ff.sck_prev;
	assign shifted  = {s_ff.shin[6:0], mosi_in};

	////////////////////////////////////////////////////////////////////////////////
	// Frame engine; deselect or not-ready drops any partial byte
	always_comb begin
		nxt_s          = s_ff;
		nxt_s.sck_prev = sck_in;
		nxt_s.wr_stb   = 1'b0;
		if (nss_n_in || !enable_in) begin
			nxt_s.bitcnt  = 3'h0;
			nxt_s.is_cmd  = 1'b1;
			nxt_s.shout   = 8'h00;
			nxt_s.miso    = 1'b0;
			nxt_s.miso_oe = 1'b0;
		end else begin
			nxt_s.miso_oe = 1'b1;
			if (sck_rise) begin
				nxt_s.shin   = shifted;
				nxt_s.bitcnt = s_ff.bitcnt + 3'h1;
				if (s_ff.bitcnt == 3'h7) begin
					if (s_ff.is_cmd) begin
						nxt_s.wnr    = shifted[7];
						nxt_s.addr   = shifted[6:0];
						nxt_s.is_cmd = 1'b0;
					end else begin
						// Burst access walks up the address space
						nxt_s.wr_stb  = s_ff.wnr;
						nxt_s.wr_addr = s_ff.addr;
						nxt_s.wr_data = shifted;
						nxt_s.addr    = s_ff.addr + 7'h01;
					end
				end
			end else if (sck_fall) begin
				if (s_ff.bitcnt == 3'h0 && !s_ff.is_cmd && !s_ff.wnr) begin
					// Load read data ahead of the first rising edge of the byte
					nxt_s.miso  = rd_data_in[7];
					nxt_s.shout = {rd_data_in[6:0], 1'b0};
				end else begin
					nxt_s.miso  = s_ff.shout[7];
					nxt_s.shout = {s_ff.shout[6:0], 1'b0};
				end
			end
		end
	end

	always_ff @(posedge ref_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			s_ff        <= '0;
			s_ff.is_cmd <= 1'b1;
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign rd_addr_out = s_ff.addr;
	assign wr_stb_out  = s_ff.wr_stb;
	assign wr_addr_out = s_ff.wr_addr;
	assign wr_data_out = s_ff.wr_data;
	assign miso_out    = s_ff.miso;
	assign miso_oe_out = s_ff.miso_oe;

endmodule // tsr_spi_slave

`default_nettype wire

//--- src/tsr_top.sv
// Thermal measurement, test/tuning registers and reset sequencing behind the SPI port
//
// Behaviour
// [R1] Start bit three starts measurement, reads zero
// [R2] Running bit two high during measurement
// [R3] Host avoids receiver while measurement runs
// [R4] Eight-bit result, minus one degree per LSB
// [R5] Sensitivity register applied as host writes
// [R6] Host sets power tune A 0x5D/0x55
// [R7] Host sets power tune B 0x7C/0x70
// [R8] Fading gain register applied as host writes
// [R9] Offset equals register times 488 Hz
// [R10] Host waits 10 ms after power-on
// [R11] Host leaves reset pin floating at power-on
// [R12] Manual reset pulse, then 5 ms wait
// [R13] Clock output starts once ready
// [R14] Start while running is ignored
`timescale 1ns/100ps
`default_nettype none
`include "tsr_regs.svh"

////////////////////////////////////////////////////////////////////////////////
// Register map behind the port
//   0x4e  temperature control
//         bit 3 start, write only, reads 0
//         bit 2 running, read only
//         bits 1-0 read 01, bits 7-4 read 0
//   0x4f  temperature result, raw code
//   0x58  receive sensitivity tuning
//   0x5a  high-power tuning, first
//   0x5c  high-power tuning, second
//   0x6f  fading-margin gain control
//   0x71  narrow-index offset, 488 Hz each
// Other addresses read zero, drop writes.
// A burst may cross a hole harmlessly.
//
// Frame on the port
//   Select low, then a command byte:
//   bit 7 set for write, bits 6-0 address.
//   Data bytes follow, MSB first; the
//   address steps up by one per byte.
//   A byte cut by deselect is dropped.
//   Read bits change on link clock falls
//   and are taken just before the next fall.
//
// Phases
//   BOOT  wake-up count after any reset;
//         port deaf, clock output low.
//   IDLE  registers live; start goes on.
//   MEAS  fixed measurement time, then
//         the code is captured and the
//         phase returns to IDLE.
// Clock output toggles once BOOT ends,
// so a host may watch it, not a timer.
//
// Trade-offs and limits
//   Result kept raw; host calibrates.
//   Result latched once, never torn.
//   Sensor code must be steady on the
//   last measuring cycle.
//   Pin reset passes four flops, so a
//   pulse under a few clocks is missed.
//   Link half period must cover three
//   clocks or bits are lost; the link
//   clock is sampled, never a clock.
//   Tuning codes apply as written;
//   picking legal codes is the host's.
//   The offset output is zero from one
//   clock after narrow-index correction is off.
//
// Status
//   The running bit and the status pin
//   come from one flop, so they agree;
//   the host keeps off the receiver
//   while either is high.
//   A second start while running is
//   dropped, not queued.
//
// Resets
//   Either reset reloads every register
//   and restarts the wake-up count.

module tsr_top
	import tsr_pkg::*;
#(
	parameter int unsigned READY_CYCLES = `TSR_READY_WAIT_US * (`TSR_CLK_HZ / `TSR_US_PER_S)
) (
	input  wire logic        ref_clk_in,
	input  wire logic        resetn_in,
	input  wire logic        reset_pin_in,
	input  wire logic        spi_sck_in,
	input  wire logic        spi_nss_n_in,
	input  wire logic        spi_mosi_in,
	input  wire logic [7:0]  thermal_code_in,
	input  wire logic        narrow_index_correction_enable_in,
	output logic             spi_miso_out,
	output logic             spi_miso_oe_out,
	output logic             reference_clock_output_out,
	output logic             thermal_sample_in_progress_out,
	output logic [7:0]       rx_gain_select_out,
	output logic [7:0]       high_power_setting_a_out,
	output logic [7:0]       high_power_setting_b_out,
	output logic [7:0]       fading_margin_select_out,
	output logic [16:0]      narrow_index_offset_hz_out
);

	localparam int unsigned MEAS_CYCLES = `TSR_MEAS_TIME_US * (`TSR_CLK_HZ / `TSR_US_PER_S);
	localparam logic [15:0] READY_LAST  = 16'(READY_CYCLES - 1);
	localparam logic [15:0] MEAS_LAST   = 16'(MEAS_CYCLES - 1);

	// Whole block state, registered once per clock
	tsr_top_state_t s_ff;
	tsr_top_state_t nxt_s;
	// Pins after synchronisation
	logic           sck_sync;
	logic           nss_sync;
	logic           mosi_sync;
	logic           pin_reset_sync;
	// Register port side
	logic [6:0]     rd_addr;
	logic [7:0]     rd_data;
	logic           wr_stb;
	logic [6:0]     wr_addr;
	logic [7:0]     wr_data;
	logic           meas_running;

	////////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers; the SPI clock is sampled, not used as a clock
	// Link clock idles low, so its filter resets low and shows no false edge
	tsr_sync3 #(.RESET_LEVEL(1'b0)) u_sync_sck (
		.ref_clk_in (ref_clk_in),
		.resetn_in  (resetn_in),
		.async_in   (spi_sck_in),
		.sync_out   (sck_sync)
	);

	// Select idles high; resetting high avoids a false frame start
	tsr_sync3 #(.RESET_LEVEL(1'b1)) u_sync_nss (
		.ref_clk_in (ref_clk_in),
		.resetn_in  (resetn_in),
		.async_in   (spi_nss_n_in),
		.sync_out   (nss_sync)
	);

	// Data takes the same path, so its lag equals that of the link clock
	tsr_sync3 #(.RESET_LEVEL(1'b0)) u_sync_mosi (
		.ref_clk_in (ref_clk_in),
		.resetn_in  (resetn_in),
		.async_in   (spi_mosi_in),
		.sync_out   (mosi_sync)
	);

	// Reset pin is active high; a floating pin is expected to read low
	tsr_sync3 #(.RESET_LEVEL(1'b0)) u_sync_rst (
		.ref_clk_in (ref_clk_in),
		.resetn_in  (resetn_in),
		.async_in   (reset_pin_in),
		.sync_out   (pin_reset_sync)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Register port; transactions before readiness are dropped
	tsr_spi_slave u_spi (
		.ref_clk_in  (ref_clk_in),
		.resetn_in   (resetn_in),
		.enable_in   (s_ff.ready),
		.sck_in      (sck_sync),
		.nss_n_in    (nss_sync),
		.mosi_in     (mosi_sync),
		.rd_data_in  (rd_data),
		.rd_addr_out (rd_addr),
		.wr_stb_out  (wr_stb),
		.wr_addr_out (wr_addr),
		.wr_data_out (wr_data),
		.miso_out    (spi_miso_out),
		.miso_oe_out (spi_miso_oe_out)
	);

	// Running flag comes from its own flop, shared by status bit and pin
	assign meas_running = s_ff.busy;

	////////////////////////////////////////////////////////////////////////////////
	// Read mux; the start bit has no storage so it always reads zero
	always_comb begin
		if (rd_addr == `TSR_ADDR_TEMP_CTRL) begin
			rd_data = `TSR_TEMP_CTRL_FIXED;
			rd_data[`TSR_TEMP_RUN_BIT] = meas_running; // [R2]
		end else if (rd_addr == `TSR_ADDR_TEMP_RESULT) begin
			rd_data = s_ff.temp_result; // [R4]
		end else if (rd_addr == `TSR_ADDR_RX_SENS) begin
			rd_data = s_ff.rx_sens;
		end else if (rd_addr == `TSR_ADDR_PA_A) begin
			rd_data = s_ff.pa_a;
		end else if (rd_addr == `TSR_ADDR_PA_B) begin
			rd_data = s_ff.pa_b;
		end else if (rd_addr == `TSR_ADDR_FADING) begin
			rd_data = s_ff.fading;
		end else if (rd_addr == `TSR_ADDR_OFFSET) begin
			rd_data = s_ff.offset;
		end else begin
			rd_data = `TSR_RD_UNMAPPED;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Sequencing, measurement and register writes
	always_comb begin
		nxt_s = s_ff;
		case (s_ff.phase)
			TSR_BOOT: begin
				// Hold off until the wake-up time has elapsed
				nxt_s.ready_cnt = s_ff.ready_cnt + 16'h0001;
				if (s_ff.ready_cnt == READY_LAST) begin
					nxt_s.phase = TSR_IDLE;
					nxt_s.ready = 1'b1;
				end
			end
			TSR_IDLE: begin
				nxt_s.meas_cnt = 16'h0000;
			end
			TSR_MEAS: begin
				// Result latched once, at the end, so a read never sees a torn value
				nxt_s.meas_cnt = s_ff.meas_cnt + 16'h0001;
				if (s_ff.meas_cnt == MEAS_LAST) begin
					nxt_s.phase       = TSR_IDLE; // [R2]
					nxt_s.temp_result = thermal_code_in; // [R4]
				end
			end
			default: begin
				nxt_s.phase = TSR_BOOT;
			end
		endcase

		// Port writes; unmapped addresses fall through untouched
		// The port is deaf in BOOT, so a write never meets the wake-up count
		if (wr_stb) begin
			if (wr_addr == `TSR_ADDR_TEMP_CTRL) begin
				// A start while busy neither restarts nor extends the measurement
				if (wr_data[`TSR_TEMP_START_BIT] && s_ff.phase == TSR_IDLE) begin // [R14]
					nxt_s.phase    = TSR_MEAS; // [R1]
					nxt_s.meas_cnt = 16'h0000;
				end
			end else if (wr_addr == `TSR_ADDR_RX_SENS) begin
				nxt_s.rx_sens = wr_data; // [R5]
			end else if (wr_addr == `TSR_ADDR_PA_A) begin
				nxt_s.pa_a = wr_data;
			end else if (wr_addr == `TSR_ADDR_PA_B) begin
				nxt_s.pa_b = wr_data;
			end else if (wr_addr == `TSR_ADDR_FADING) begin
				nxt_s.fading = wr_data; // [R8]
			end else if (wr_addr == `TSR_ADDR_OFFSET) begin
				nxt_s.offset = wr_data;
			end
		end

		// Frequency offset only applies while narrow-index correction is on
		if (narrow_index_correction_enable_in) begin
			nxt_s.offset_hz = 17'(s_ff.offset) * `TSR_HZ_PER_LSB; // [R9]
		end else begin
			nxt_s.offset_hz = 17'h00000;
		end

		// Clock output stays quiet until ready, so its onset marks readiness
		nxt_s.reference_clock_output = s_ff.ready ? ~s_ff.reference_clock_output : 1'b0; // [R13]

		// Manual reset pin restarts the whole sequence and the registers
		if (pin_reset_sync) begin // [R12]
			nxt_s             = '0;
			nxt_s.phase       = TSR_BOOT;
			nxt_s.temp_result = `TSR_RST_TEMP;
			nxt_s.rx_sens     = `TSR_RST_RX_SENS;
			nxt_s.pa_a        = `TSR_RST_PA_A;
			nxt_s.pa_b        = `TSR_RST_PA_B;
			nxt_s.fading      = `TSR_RST_FADING;
			nxt_s.offset      = `TSR_RST_OFFSET;
		end

		// Running flag follows the final phase, so the status pin is a flop
		nxt_s.busy = (nxt_s.phase == TSR_MEAS); // [R2]
	end

	// State register; the asynchronous reset loads only constants
	always_ff @(posedge ref_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			s_ff             <= '0;
			s_ff.phase       <= TSR_BOOT;
			s_ff.temp_result <= `TSR_RST_TEMP;
			s_ff.rx_sens     <= `TSR_RST_RX_SENS;
			s_ff.pa_a        <= `TSR_RST_PA_A;
			s_ff.pa_b        <= `TSR_RST_PA_B;
			s_ff.fading      <= `TSR_RST_FADING;
			s_ff.offset      <= `TSR_RST_OFFSET;
		end else begin
			s_ff <= nxt_s;
		end
	end

	// Outputs straight from the state register
	assign reference_clock_output_out     = s_ff.reference_clock_output;
	assign thermal_sample_in_progress_out = s_ff.busy; // [R2] [R3]
	assign rx_gain_select_out             = s_ff.rx_sens;
	assign high_power_setting_a_out       = s_ff.pa_a;
	assign high_power_setting_b_out       = s_ff.pa_b;
	assign fading_margin_select_out       = s_ff.fading;
	assign narrow_index_offset_hz_out     = s_ff.offset_hz;

endmodule // tsr_top

`default_nettype wire

//--- verification/tsr_top_asserts.sv
// Port-level checker of the thermal/test register block
`timescale 1ns/100ps
`default_nettype none

module tsr_top_asserts #(
	parameter int unsigned READY_CYCLES = 20
) (
	input wire logic        ref_clk_in,
	input wire logic        resetn_in,
	input wire logic        reset_pin_in,
	input wire logic        spi_nss_n_in,
	input wire logic        narrow_index_correction_enable_in,
	input wire logic        spi_miso_oe_out,
	input wire logic        reference_clock_output_out,
	input wire logic        thermal_sample_in_progress_out,
	input wire logic [7:0]  rx_gain_select_out,
	input wire logic [7:0]  high_power_setting_a_out,
	input wire logic [7:0]  high_power_setting_b_out,
	input wire logic [7:0]  fading_margin_select_out,
	input wire logic [16:0] narrow_index_offset_hz_out
);
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (!resetn_in);

	// Length of the running measurement, so a restart that stretches it shows up
	logic [15:0] busy_cnt_ff;
	always_ff @(posedge ref_clk_in or negedge resetn_in) begin
		if (!resetn_in)
			busy_cnt_ff <= 16'h0000;
		else if (thermal_sample_in_progress_out)
			busy_cnt_ff <= busy_cnt_ff + 16'h0001;
		else
			busy_cnt_ff <= 16'h0000;
	end

	// Quiet cycles after power-on reset, up to the first clock output rise
	logic [15:0] boot_cnt_ff;
	logic        seen_ff;
	always_ff @(posedge ref_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			boot_cnt_ff <= 16'h0000;
			seen_ff     <= 1'b0;
		end else if (reference_clock_output_out) begin
			seen_ff <= 1'b1;
		end else if (!seen_ff) begin
			boot_cnt_ff <= boot_cnt_ff + 16'h0001;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	sequence s_quiet;
		!reference_clock_output_out [*8];
	endsequence
	property p_boot;
		$rose(resetn_in) |-> s_quiet;
	endproperty
	a_boot: assert property (p_boot) else $error("clock output active during boot");
	property p_clk_fall;
		reference_clock_output_out |=> !reference_clock_output_out;
	endproperty
	a_clk_fall: assert property (p_clk_fall) else $error("clock output stuck high");
	property p_rst_vals;
		$rose(resetn_in) |-> rx_gain_select_out == 8'h1b && high_power_setting_a_out == 8'h55
			&& high_power_setting_b_out == 8'h70 && fading_margin_select_out == 8'h30;
	endproperty
	a_rst_vals: assert property (p_rst_vals) else $error("tuning reset values wrong");
	property p_off_gate;
		!narrow_index_correction_enable_in && !$past(narrow_index_correction_enable_in)
			|-> narrow_index_offset_hz_out == 17'h00000;
	endproperty
	a_off_gate: assert property (p_off_gate) else $error("offset present while off");
	property p_off_mul;
		(narrow_index_offset_hz_out % 17'h001e8) == 17'h00000;
	endproperty
	a_off_mul: assert property (p_off_mul) else $error("offset not a 488 Hz multiple");
	// Pin reset may cut a measurement short, so it is excused here
	property p_busy_len;
		disable iff (!resetn_in || reset_pin_in)
		$fell(thermal_sample_in_progress_out) |-> busy_cnt_ff == 16'h03e8;
	endproperty
	a_busy_len: assert property (p_busy_len) else $error("measurement length wrong");
	property p_busy_src;
		$rose(thermal_sample_in_progress_out) |-> !spi_nss_n_in;
	endproperty
	a_busy_src: assert property (p_busy_src) else $error("measurement began unasked");
	property p_oe_idle;
		spi_nss_n_in [*6] |-> !spi_miso_oe_out;
	endproperty
	a_oe_idle: assert property (p_oe_idle) else $error("data out driven while deselected");
	// Wake-up count plus the one cycle before the first toggle
	property p_ready_len;
		$rose(reference_clock_output_out) && !seen_ff |-> boot_cnt_ff == READY_CYCLES + 1;
	endproperty
	a_ready_len: assert property (p_ready_len) else $error("clock output onset mistimed");
endmodule // tsr_top_asserts

`default_nettype wire

//--- verification/tsr_host_model.sv
// Host microcontroller model: SPI mode 0 master for register frames
`timescale 1ns/100ps
`default_nettype none

module tsr_host_model (
	input  wire logic clk_in,
	input  wire logic miso_in,
	input  wire logic miso_oe_in,
	output logic      sck_out,
	output logic      nss_n_out,
	output logic      mosi_out
);
	// Link clock stands low outside frames
	initial begin
		sck_out = 1'b0;
		nss_n_out = 1'b1;
		mosi_out = 1'b0;
	end

	// Half period of four reference clocks gives the 800 ns link clock
	task automatic half();
		repeat (4) @(negedge clk_in);
	endtask

	// One byte MSB first; read data is taken late in the high phase, clear of the sync lag
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--) begin
			mosi_out = tx[i];
			half();
			sck_out = 1'b1;
			half();
			rx[i] = miso_oe_in ? miso_in : 1'bx;
			sck_out = 1'b0;
		end
	endtask

	// Frame: command byte then n data bytes; select held past the last bit for the commit
	task automatic access(input logic wr, input logic [6:0] a, input logic [7:0] d [3],
		input int n, output logic [7:0] r);
		logic [7:0] dummy;
		nss_n_out = 1'b0;
		half();
		xfer({wr, a}, dummy);
		for (int k = 0; k < n; k++)
			xfer(d[k], r);
		half();
		half();
		nss_n_out = 1'b1;
		mosi_out = ~mosi_out; // Released line shows no stale value
		half();
	endtask
endmodule // tsr_host_model

`default_nettype wire

//--- verification/tb_tsr_top.sv
// Self-checking testbench of the thermal/test register block
`timescale 1ns/100ps
`default_nettype none

module tb_tsr_top;
	logic        clk, resetn, pin, sck, nss_n, mosi, miso, oe, en, clko, busy;
	logic [7:0]  code, rx, pa, pb, fade;
	logic [16:0] hz;
	int          mismatches, n_checks;

	tsr_top #(.READY_CYCLES(20)) i_tsr_top (
		.ref_clk_in(clk), .resetn_in(resetn), .reset_pin_in(pin),
		.spi_sck_in(sck), .spi_nss_n_in(nss_n), .spi_mosi_in(mosi),
		.thermal_code_in(code), .narrow_index_correction_enable_in(en),
		.spi_miso_out(miso), .spi_miso_oe_out(oe), .reference_clock_output_out(clko),
		.thermal_sample_in_progress_out(busy), .rx_gain_select_out(rx),
		.high_power_setting_a_out(pa), .high_power_setting_b_out(pb),
		.fading_margin_select_out(fade), .narrow_index_offset_hz_out(hz));
	tsr_host_model i_tsr_host_model (.clk_in(clk), .miso_in(miso), .miso_oe_in(oe),
		.sck_out(sck), .nss_n_out(nss_n), .mosi_out(mosi));

	////////////////////////////////////////////////////////////////////////////////
	task automatic final_report();
		$display("Checks %0d, mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		n_checks++;
		if (g !== e) begin
			mismatches++;
			$display("Error at %0t: got %h, expected %h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		logic [7:0] r;
		i_tsr_host_model.access(1'b1, a, '{d, 8'h00, 8'h00}, 1, r);
	endtask
	task automatic rd_chk(input logic [6:0] a, input logic [7:0] e);
		logic [7:0] r;
		i_tsr_host_model.access(1'b0, a, '{8'h00, 8'h00, 8'h00}, 1, r);
		chk(r, e);
	endtask
	// Clock output activity stands in for the fixed post-reset wait
	task automatic wait_ready();
		for (int i = 0; i < 400 && clko !== 1'b1; i++)
			@(negedge clk);
		chk({7'h00, clko}, 8'h01);
		repeat (2) @(negedge clk);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Register reset values, control readback and an unmapped hole
	task automatic t_reset_vals();
		logic [6:0] ta [8] = '{7'h58, 7'h5a, 7'h5c, 7'h6f, 7'h71, 7'h4e, 7'h4f, 7'h50};
		logic [7:0] tv [8] = '{8'h1b, 8'h55, 8'h70, 8'h30, 8'h00, 8'h01, 8'h00, 8'h00};
		for (int i = 0; i < 8; i++)
			rd_chk(ta[i], tv[i]);
	endtask
	// Tuning writes, a burst across an unmapped hole, and three fading values
	task automatic t_tune();
		logic [7:0] r;
		logic [7:0] fv [3] = '{8'h00, 8'h20, 8'h30};
		wr(7'h58, 8'h2d);
		chk(rx, 8'h2d);
		rd_chk(7'h58, 8'h2d);
		i_tsr_host_model.access(1'b1, 7'h5a, '{8'h5d, 8'ha5, 8'h7c}, 3, r);
		chk(pa, 8'h5d);
		chk(pb, 8'h7c);
		rd_chk(7'h5b, 8'h00);
		wr(7'h5a, 8'h55);
		wr(7'h5c, 8'h70);
		chk(pa, 8'h55);
		chk(pb, 8'h70);
		for (int i = 0; i < 3; i++) begin
			wr(7'h6f, fv[i]);
			chk(fade, fv[i]);
		end
	endtask
	// Offset gated by the enable and scaled by 488 Hz; 255 x 488 = 124440
	task automatic t_offset();
		wr(7'h71, 8'hff);
		repeat (3) @(negedge clk);
		chk({7'h00, hz == 17'h00000}, 8'h01);
		en = 1'b1;
		repeat (3) @(negedge clk);
		chk({7'h00, hz === 17'h1e618}, 8'h01);
		en = 1'b0;
	endtask
	// Measurement with a second start while running; length judged by the checker
	task automatic t_meas();
		code = 8'he7;
		wr(7'h4e, 8'h08);
		rd_chk(7'h4e, 8'h05);
		wr(7'h4e, 8'h08);
		chk({7'h00, busy}, 8'h01);
		// Host keeps off the receiver settings until the running flag drops
		for (int i = 0; i < 1200 && busy !== 1'b0; i++)
			@(negedge clk);
		chk({7'h00, busy}, 8'h00);
		rd_chk(7'h4f, 8'he7);
		rd_chk(7'h4e, 8'h01);
	endtask
	// Manual reset pulse of 100 us, then ready signalled by the clock output
	task automatic t_pin();
		pin = 1'b1;
		repeat (1000) @(negedge clk);
		chk({7'h00, clko}, 8'h00);
		pin = 1'b0;
		wait_ready();
		chk(rx, 8'h1b);
		rd_chk(7'h58, 8'h1b);
		rd_chk(7'h4f, 8'h00);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// Cut a hang after about five times the expected run
	initial begin
		#3000000;
		mismatches++;
		$display("Error at %0t: watchdog expired", $time);
		final_report();
	end
	// Pin kept inactive through power-on, as a floating pin reads here
	initial begin
		resetn = 1'b0;
		pin = 1'b0;
		en = 1'b0;
		code = 8'h3c;
		mismatches = 0;
		n_checks = 0;
		repeat (16) @(negedge clk);
		resetn = 1'b1;
		wait_ready();
		t_reset_vals();
		t_tune();
		t_offset();
		t_meas();
		t_pin();
		final_report();
	end
endmodule // tb_tsr_top

bind tsr_top tsr_top_asserts #(.READY_CYCLES(READY_CYCLES)) i_tsr_top_asserts (
	.ref_clk_in(ref_clk_in), .resetn_in(resetn_in), .reset_pin_in(reset_pin_in),
	.spi_nss_n_in(spi_nss_n_in),
	.narrow_index_correction_enable_in(narrow_index_correction_enable_in),
	.spi_miso_oe_out(spi_miso_oe_out),
	.reference_clock_output_out(reference_clock_output_out),
	.thermal_sample_in_progress_out(thermal_sample_in_progress_out),
	.rx_gain_select_out(rx_gain_select_out),
	.high_power_setting_a_out(high_power_setting_a_out),
	.high_power_setting_b_out(high_power_setting_b_out),
	.fading_margin_select_out(fading_margin_select_out),
	.narrow_index_offset_hz_out(narrow_index_offset_hz_out));

`default_nettype wire
